/* rtl/pdl_port_regs.sv */
// Register bank for diagnostics and link control of the two PHY ports
//
// Functional notes
// - Two-bit outcome code, read-only, resets normal
// - Writing trigger starts test; clears on completion
// - Trigger reads zero once results are valid
// - Port 1 loopback: receive pair to transmit
// - Port 2 loopback: receive pair to transmit
// - Nine-bit fault count split across two registers
// - Fault distance is 0.4 m per count
// - Autoneg enable; else bits 6,5 set mode
// - Forced speed: one 100M, zero 10M
// - Autoneg enable resets from per-port strap
// - Forced speed resets from per-port strap
// - Duplex bit forces full/half when autoneg off/failed
//
// Our own choice: the Avalon-MM register port.
module pdl_port_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [pdl_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pdl_pkg::AVS_DATA_W-1:0] avs_writedata,
  output logic [pdl_pkg::AVS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic port1_autoneg_strap,
  input wire logic port2_autoneg_strap,
  input wire logic port1_speed_strap,
  input wire logic port2_speed_strap,
  input wire pdl_pkg::pdl_phy_stat_type [1:0] phy_stat,
  output pdl_pkg::pdl_phy_ctrl_type [1:0] phy_ctrl
);

  localparam int unsigned NP = pdl_pkg::NUM_PORTS;
  // Top bit of the outcome code field in the test control register
  localparam int unsigned TC_HI = pdl_pkg::TC_CODE_LSB + 1;

  // Bus slave state
  logic wait_ff; // Registered waitrequest, high when idle
  logic [pdl_pkg::AVS_DATA_W-1:0] rdata_ff; // Registered read data
  logic [pdl_pkg::AVS_DATA_W-1:0] nxt_rdata; // Read mux result
  logic cfg_ready_ff; // Straps loaded, bus may be served
  logic req; // A read or write is pending
  logic wr_go; // Write accepted at this edge
  logic [NP-1:0] sel_test; // Address hits test control register
  logic [NP-1:0] sel_dist; // Address hits fault distance register
  logic [NP-1:0] sel_link; // Address hits link control register

  // Software controls
  logic [NP-1:0] force_link_ff; // Link pass override
  logic [NP-1:0] loopback_ff; // Remote loopback enable
  logic [NP-1:0] an_en_ff; // Auto-negotiation enable
  logic [NP-1:0] speed_ff; // Forced speed, one is 100M
  logic [NP-1:0] duplex_ff; // Forced duplex, one is full

  // Cable test engine outputs
  logic [NP-1:0] busy; // Trigger bit as read back
  logic [NP-1:0] eng_start; // Start pulse toward PHY
  logic [NP-1:0] test_go; // Accepted trigger write
  pdl_pkg::pdl_test_state_type eng_state [NP]; // Sequencer states
  pdl_pkg::pdl_cable_code_type eng_code [NP]; // Outcome codes
  logic [pdl_pkg::COUNT_W-1:0] eng_count [NP]; // Fault counts

  // Strap capture
  logic [2*NP-1:0] strap_in; // Speed straps above autoneg straps
  logic [2*NP-1:0] strap_q; // Captured strap levels
  logic strap_load; // Pulse: load strapped fields
  logic strap_valid; // Straps have been captured

  assign strap_in = {port2_speed_strap, port1_speed_strap,
                     port2_autoneg_strap, port1_autoneg_strap};

  // Straps are caught after release, not inside the async reset
  pdl_strap_latch #(
    .W(2 * NP)
  ) u_strap (
    .clk(clk),
    .resetn(resetn),
    .strap_in(strap_in),
    .strap_ff(strap_q),
    .load_ff(strap_load),
    .valid_ff(strap_valid)
  );

  // Address decode against the per-port register indices
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      sel_test[p] = (avs_address == pdl_pkg::TEST_CTRL_IDX[p]);
      sel_dist[p] = (avs_address == pdl_pkg::FAULT_DIST_IDX[p]);
      sel_link[p] = (avs_address == pdl_pkg::LINK_CTRL_IDX[p]);
    end
  end

  assign req = avs_read || avs_write;
  assign wr_go = avs_write && !wait_ff;

  // Bus is held off until strapped values are in place
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ready_ff <= 1'h0;
    end else if (strap_load) begin
      cfg_ready_ff <= 1'h1;
    end
  end

  // One wait cycle per access, then a single accept cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff <= 1'h1;
    end else begin
      wait_ff <= !(req && wait_ff && cfg_ready_ff);
    end
  end

  // Read mux; unmapped addresses and unused bits read as zero
  always_comb begin
    nxt_rdata = '0;
    for (int p = 0; p < NP; p++) begin
      if (sel_test[p]) begin
        nxt_rdata[TC_HI:pdl_pkg::TC_CODE_LSB] = eng_code[p];
        nxt_rdata[pdl_pkg::TC_TRIGGER_BIT] = busy[p];
        nxt_rdata[pdl_pkg::TC_FORCE_LINK_BIT] = force_link_ff[p];
        nxt_rdata[pdl_pkg::TC_LOOPBACK_BIT] = loopback_ff[p];
        nxt_rdata[pdl_pkg::TC_COUNT_MSB_BIT] = eng_count[p][8];
      end
      if (sel_dist[p]) begin
        nxt_rdata[7:0] = eng_count[p][7:0];
      end
      if (sel_link[p]) begin
        nxt_rdata[pdl_pkg::LC_AN_EN_BIT] = an_en_ff[p];
        nxt_rdata[pdl_pkg::LC_SPEED_BIT] = speed_ff[p];
        nxt_rdata[pdl_pkg::LC_DUPLEX_BIT] = duplex_ff[p];
      end
    end
  end

  // Read data sampled as waitrequest drops, stable through the accept cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= '0;
    end else if (avs_read && wait_ff && cfg_ready_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // Test control register writes: override and loopback bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_link_ff <= {NP{pdl_pkg::FORCE_LINK_RST}};
      loopback_ff <= {NP{pdl_pkg::LOOPBACK_RST}};
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_go && sel_test[p]) begin
          force_link_ff[p] <= avs_writedata[pdl_pkg::TC_FORCE_LINK_BIT];
          loopback_ff[p] <= avs_writedata[pdl_pkg::TC_LOOPBACK_BIT];
        end
      end
    end
  end

  // Link control register: autoneg and speed strapped at reset, duplex constant, then software owned
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      an_en_ff <= {NP{pdl_pkg::AN_EN_NOMINAL}};
      speed_ff <= {NP{pdl_pkg::SPEED_NOMINAL}};
      duplex_ff <= {NP{pdl_pkg::DUPLEX_RST}};
    end else if (strap_load) begin
      an_en_ff <= strap_q[NP-1:0];
      speed_ff <= strap_q[2*NP-1:NP];
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_go && sel_link[p]) begin
          an_en_ff[p] <= avs_writedata[pdl_pkg::LC_AN_EN_BIT];
          speed_ff[p] <= avs_writedata[pdl_pkg::LC_SPEED_BIT];
          duplex_ff[p] <= avs_writedata[pdl_pkg::LC_DUPLEX_BIT];
        end
      end
    end
  end

  // One sequencer per port; writing zero to the trigger does nothing
  for (genvar g = 0; g < NP; g++) begin : g_port
    assign test_go[g] = wr_go && sel_test[g]
                        && avs_writedata[pdl_pkg::TC_TRIGGER_BIT];

    pdl_cable_test #(
      .CW(pdl_pkg::COUNT_W)
    ) u_test (
      .clk(clk),
      .resetn(resetn),
      .start(test_go[g]),
      .phy_done(phy_stat[g].test_done),
      .phy_code(phy_stat[g].test_code),
      .phy_count(phy_stat[g].test_count),
      .busy_ff(busy[g]),
      .phy_start_ff(eng_start[g]),
      .state_ff(eng_state[g]),
      .code_ff(eng_code[g]),
      .count_ff(eng_count[g])
    );
  end

  // PHY controls, all registered so the outputs come from flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phy_ctrl <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        phy_ctrl[p].an_enable <= an_en_ff[p];
        phy_ctrl[p].speed_100 <= speed_ff[p];
        // Duplex bit only matters without a negotiated result
        phy_ctrl[p].duplex_forced <= !an_en_ff[p]
                                     || phy_stat[p].an_failed;
        phy_ctrl[p].duplex_full <= duplex_ff[p];
        // PHY turns receive pair back onto transmit pair at PMD/PMA
        phy_ctrl[p].remote_loopback <= loopback_ff[p];
        phy_ctrl[p].link_pass <= force_link_ff[p]
                                 || phy_stat[p].link_detect;
        phy_ctrl[p].cable_test_start <= eng_start[p];
      end
    end
  end

  // Checks, one set per port
  for (genvar a = 0; a < NP; a++) begin : g_chk

    property p_code_on_done;
      @(posedge clk) disable iff (!resetn)
      (eng_code[a] != $past(eng_code[a]))
        |-> $past(eng_state[a] == pdl_pkg::PDL_TEST_WAIT
                  && phy_stat[a].test_done);
    endproperty
    a_code_on_done: assert property (p_code_on_done)
      else $error("outcome code changed outside test completion");

    property p_trigger_start;
      @(posedge clk) disable iff (!resetn)
      (test_go[a] && !busy[a])
        |=> busy[a] ##1 phy_ctrl[a].cable_test_start;
    endproperty
    a_trigger_start: assert property (p_trigger_start)
      else $error("trigger write did not start a cable test");

    property p_self_clear;
      @(posedge clk) disable iff (!resetn)
      (eng_state[a] == pdl_pkg::PDL_TEST_WAIT && phy_stat[a].test_done)
        |=> !busy[a];
    endproperty
    a_self_clear: assert property (p_self_clear)
      else $error("trigger bit not cleared at completion");

    property p_trigger_readback;
      @(posedge clk) disable iff (!resetn)
      (avs_read && !wait_ff && sel_test[a])
        |-> avs_readdata[pdl_pkg::TC_TRIGGER_BIT] == $past(busy[a]);
    endproperty
    a_trigger_readback: assert property (p_trigger_readback)
      else $error("trigger read back does not match test state");

    property p_results_hold;
      @(posedge clk) disable iff (!resetn)
      (busy[a] && !phy_stat[a].test_done) |=>
        (eng_count[a] == $past(eng_count[a]));
    endproperty
    a_results_hold: assert property (p_results_hold)
      else $error("fault count moved while a test was running");

    property p_link_pass;
      @(posedge clk) disable iff (!resetn)
      force_link_ff[a] |=> phy_ctrl[a].link_pass;
    endproperty
    a_link_pass: assert property (p_link_pass)
      else $error("link not passing with override set");

    property p_loopback;
      @(posedge clk) disable iff (!resetn)
      (wr_go && sel_test[a]) |=> ##1
        (phy_ctrl[a].remote_loopback
         == $past(avs_writedata[pdl_pkg::TC_LOOPBACK_BIT], 2));
    endproperty
    a_loopback: assert property (p_loopback)
      else $error("remote loopback does not follow written bit");

    property p_count_split;
      @(posedge clk) disable iff (!resetn)
      (avs_read && !wait_ff && sel_dist[a])
        |-> avs_readdata[7:0] == $past(eng_count[a][7:0]);
    endproperty
    a_count_split: assert property (p_count_split)
      else $error("fault count low byte read back wrong");

    property p_speed_write;
      @(posedge clk) disable iff (!resetn)
      (wr_go && sel_link[a]) |=> ##1
        (phy_ctrl[a].speed_100
         == $past(avs_writedata[pdl_pkg::LC_SPEED_BIT], 2)
         && phy_ctrl[a].an_enable
         == $past(avs_writedata[pdl_pkg::LC_AN_EN_BIT], 2));
    endproperty
    a_speed_write: assert property (p_speed_write)
      else $error("speed or autoneg output does not follow write");

    property p_strap_load;
      @(posedge clk) disable iff (!resetn)
      strap_load |=> (an_en_ff[a] == $past(strap_q[a])
                      && speed_ff[a] == $past(strap_q[NP + a]));
    endproperty
    a_strap_load: assert property (p_strap_load)
      else $error("strapped fields not loaded from straps");

    property p_duplex_forced;
      @(posedge clk) disable iff (!resetn)
      (!an_en_ff[a]) |=> phy_ctrl[a].duplex_forced;
    endproperty
    a_duplex_forced: assert property (p_duplex_forced)
      else $error("duplex not forced with autoneg off");

    // The PHY must see exactly one start per accepted trigger
    property p_start_pulse;
      @(posedge clk) disable iff (!resetn)
      phy_ctrl[a].cable_test_start |=> !phy_ctrl[a].cable_test_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
      else $error("cable test start pulse longer than one cycle");

    // Main scenarios
    c_test_open: cover property (@(posedge clk) disable iff (!resetn)
      busy[a] ##1 (eng_code[a] == pdl_pkg::PDL_CABLE_OPEN));
    c_loopback_on: cover property (@(posedge clk) disable iff (!resetn)
      $rose(phy_ctrl[a].remote_loopback));
    c_forced_10m: cover property (@(posedge clk) disable iff (!resetn)
      phy_ctrl[a].duplex_forced && !phy_ctrl[a].speed_100);
  end

  // Bus reads of the trigger bit while a test runs
  c_busy_read: cover property (@(posedge clk) disable iff (!resetn)
    avs_read && !wait_ff && avs_readdata[pdl_pkg::TC_TRIGGER_BIT]);

  // A write served before the strap load would be overwritten by it
  property p_straps_first;
    @(posedge clk) disable iff (!resetn)
    !wait_ff |-> (strap_valid && cfg_ready_ff);
  endproperty
  a_straps_first: assert property (p_straps_first)
    else $error("bus served before strapped fields were loaded");

endmodule // pdl_port_regs

/* include/pdl_pkg.sv */
// Package for the PHY port diagnostic and link control register block
package pdl_pkg;

  // Two copper ports carry these registers; the third port has none
  localparam int unsigned NUM_PORTS = 2;

  // Avalon-MM widths; address is the register index, byte address = 4 * index
  localparam int unsigned AVS_ADDR_W = 8;
  localparam int unsigned AVS_DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices, entry 0 is port 1 and entry 1 is port 2
  localparam logic [1:0][7:0] TEST_CTRL_IDX = {8'h2a, 8'h1a};
  localparam logic [1:0][7:0] FAULT_DIST_IDX = {8'h2b, 8'h1b};
  localparam logic [1:0][7:0] LINK_CTRL_IDX = {8'h2c, 8'h1c};

  // Field positions in the cable test control register
  localparam int unsigned TC_CODE_LSB = 5;
  localparam int unsigned TC_TRIGGER_BIT = 4;
  localparam int unsigned TC_FORCE_LINK_BIT = 3;
  localparam int unsigned TC_LOOPBACK_BIT = 1;
  localparam int unsigned TC_COUNT_MSB_BIT = 0;

  // Field positions in the link control register
  localparam int unsigned LC_AN_EN_BIT = 7;
  localparam int unsigned LC_SPEED_BIT = 6;
  localparam int unsigned LC_DUPLEX_BIT = 5;

  // Fault distance count width and the distance step per count, in cm
  localparam int unsigned COUNT_W = 9;
  localparam int unsigned FAULT_STEP_CM = 40;

  // Reset values
  localparam logic [8:0] COUNT_RST = 9'h000;
  localparam logic FORCE_LINK_RST = 1'h0;
  localparam logic LOOPBACK_RST = 1'h0;
  localparam logic DUPLEX_RST = 1'h1;
  localparam logic AN_EN_NOMINAL = 1'h1;
  localparam logic SPEED_NOMINAL = 1'h1;

  // Cable test outcome codes
  typedef enum logic [1:0] {
    PDL_CABLE_NORMAL = 2'h0,
    PDL_CABLE_OPEN = 2'h1,
    PDL_CABLE_SHORT = 2'h2,
    PDL_CABLE_FAILED = 2'h3
  } pdl_cable_code_type;

  // Cable test sequencer states, one-hot
  typedef enum logic [2:0] {
    PDL_TEST_IDLE = 3'h1,
    PDL_TEST_START = 3'h2,
    PDL_TEST_WAIT = 3'h4
  } pdl_test_state_type;

  // Status from one PHY front end
  typedef struct packed {
    logic link_detect;
    logic an_failed;
    logic test_done;
    pdl_cable_code_type test_code;
    logic [8:0] test_count;
  } pdl_phy_stat_type;

  // Controls to one PHY front end
  typedef struct packed {
    logic an_enable;
    logic speed_100;
    logic duplex_forced;
    logic duplex_full;
    logic remote_loopback;
    logic link_pass;
    logic cable_test_start;
  } pdl_phy_ctrl_type;

endpackage

/* rtl/pdl_strap_latch.sv */
// Catches strap pin levels once, at the first edge after reset release
module pdl_strap_latch #(
  parameter int unsigned W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] strap_in,
  output logic [W-1:0] strap_ff,
  output logic load_ff,
  output logic valid_ff
);

  // Async reset may only load constants, so the pins are sampled on a clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_ff <= '0;
      valid_ff <= 1'h0;
    end else if (!valid_ff) begin
      strap_ff <= strap_in;
      valid_ff <= 1'h1;
    end
  end

  // One-cycle pulse telling the owner to load its strapped bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_ff <= 1'h0;
    end else begin
      load_ff <= !valid_ff;
    end
  end

endmodule // pdl_strap_latch

/* rtl/pdl_cable_test.sv */
// Cable diagnostic sequencer for one port: trigger, wait, capture result
module pdl_cable_test #(
  parameter int unsigned CW = pdl_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic phy_done,
  input wire pdl_pkg::pdl_cable_code_type phy_code,
  input wire logic [CW-1:0] phy_count,
  output logic busy_ff,
  output logic phy_start_ff,
  output pdl_pkg::pdl_test_state_type state_ff,
  output pdl_pkg::pdl_cable_code_type code_ff,
  output logic [CW-1:0] count_ff
);

  pdl_pkg::pdl_test_state_type nxt_state; // Next sequencer state

  // Next state; a new trigger while running is ignored, no abort exists
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pdl_pkg::PDL_TEST_IDLE: begin
        if (start) begin
          nxt_state = pdl_pkg::PDL_TEST_START;
        end
      end
      pdl_pkg::PDL_TEST_START: begin
        nxt_state = pdl_pkg::PDL_TEST_WAIT;
      end
      pdl_pkg::PDL_TEST_WAIT: begin
        if (phy_done) begin
          nxt_state = pdl_pkg::PDL_TEST_IDLE;
        end
      end
      default: begin
        nxt_state = pdl_pkg::PDL_TEST_IDLE;
      end
    endcase
  end

  // State and trigger bit; hardware clears the trigger on completion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= pdl_pkg::PDL_TEST_IDLE;
      busy_ff <= 1'h0;
      phy_start_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != pdl_pkg::PDL_TEST_IDLE);
      phy_start_ff <= (nxt_state == pdl_pkg::PDL_TEST_START);
    end
  end

  // Results held during the test and replaced together at completion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_ff <= pdl_pkg::PDL_CABLE_NORMAL;
      count_ff <= CW'(pdl_pkg::COUNT_RST);
    end else if (state_ff == pdl_pkg::PDL_TEST_WAIT && phy_done) begin
      code_ff <= phy_code;
      count_ff <= phy_count;
    end
  end

endmodule // pdl_cable_test

/* testbench/pdl_phy_model.sv */
// Behavioural PHY front end model for both ports: status and cable tests
module pdl_phy_model (
  input wire logic clk,
  input wire logic resetn,
  input wire pdl_pkg::pdl_phy_ctrl_type [1:0] phy_ctrl,
  input wire logic [1:0] link_up,
  input wire logic [1:0] an_fail,
  input wire logic [1:0][10:0] result,
  input wire logic [7:0] delay,
  output pdl_pkg::pdl_phy_stat_type [1:0] phy_stat,
  output logic [1:0][7:0] starts
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cycles left before a running test reports
  logic [1:0][7:0] wait_cnt;
  // Code and count as seen on the result lines
  logic [1:0][10:0] shown;
  // One-cycle completion strobe
  logic [1:0] done;

  // Count start pulses, wait, then hand over the result for one cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= '0;
      starts <= '0;
      done <= '0;
      shown <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        done[p] <= 1'b0;
        // Lines are not held outside the done cycle, so a late sample shows
        shown[p] <= ~shown[p];
        if (phy_ctrl[p].cable_test_start === 1'b1) begin
          starts[p] <= starts[p] + 8'h01;
          wait_cnt[p] <= delay;
        end else if (wait_cnt[p] == 8'h01) begin
          done[p] <= 1'b1;
          shown[p] <= result[p];
          wait_cnt[p] <= 8'h00;
        end else if (wait_cnt[p] != 8'h00) begin
          wait_cnt[p] <= wait_cnt[p] - 8'h01;
        end
      end
    end
  end

  // Status bundle toward the register block
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      phy_stat[p].link_detect = link_up[p];
      phy_stat[p].an_failed = an_fail[p];
      phy_stat[p].test_done = done[p];
      phy_stat[p].test_code = pdl_pkg::pdl_cable_code_type'(shown[p][10:9]);
      phy_stat[p].test_count = shown[p][8:0];
    end
  end
endmodule // pdl_phy_model

/* testbench/tb_top.sv */
// Self-checking bench for the PHY port diagnostic and link control block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Straps set away from nominal on some pins to prove they are sampled
  logic [3:0] strap = 4'h9;
  pdl_pkg::pdl_phy_stat_type [1:0] phy_stat;
  pdl_pkg::pdl_phy_ctrl_type [1:0] phy_ctrl;
  logic [1:0] link_up = 2'h0;
  logic [1:0] an_fail = 2'h0;
  logic [1:0][10:0] result = '0;
  logic [1:0][10:0] prev = '0;
  logic [1:0][7:0] starts;
  logic [7:0] q;
  logic [7:0] w;
  int bad_count = 0;
  int tests_run = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  pdl_port_regs DUT (
    .clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .port1_autoneg_strap(strap[0]), .port2_autoneg_strap(strap[1]),
    .port1_speed_strap(strap[2]), .port2_speed_strap(strap[3]),
    .phy_stat(phy_stat), .phy_ctrl(phy_ctrl)
  );

  pdl_phy_model PHY (
    .clk(clk), .resetn(resetn), .phy_ctrl(phy_ctrl), .link_up(link_up),
    .an_fail(an_fail), .result(result), .delay(8'h14),
    .phy_stat(phy_stat), .starts(starts)
  );

  // Verdict and end of run
  task complete_run;
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= idx;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // A stuck slave ends the run
    if (n >= 100) begin
      bad_count++;
      complete_run();
    end
    @(posedge clk);
  endtask

  // Read a register and compare with the expected byte
  task rd_chk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(q, e)
  endtask

  // Outputs are registered, so give them a few edges to land
  task settle;
    repeat (3) @(posedge clk);
  endtask

  // Full cable test on one port, with a refused retrigger mid-run
  task cable(input int p, input logic [10:0] r);
    logic [7:0] s;
    int n;
    s = starts[p];
    result[p] <= r;
    bus(1'b1, pdl_pkg::TEST_CTRL_IDX[p], 8'h10);
    bus(1'b1, pdl_pkg::TEST_CTRL_IDX[p], 8'h10);
    rd_chk(pdl_pkg::TEST_CTRL_IDX[p], {1'b0, prev[p][10:9], 4'h8,
      prev[p][8]});
    n = 0;
    // Software polls the trigger until it reads zero
    do begin
      bus(1'b0, pdl_pkg::TEST_CTRL_IDX[p], 8'h00);
      n++;
    end while (q[4] !== 1'b0 && n < 50);
    `CHK(n < 50, 1'b1)
    // A trigger that never clears ends the run
    if (n >= 50) begin
      complete_run();
    end
    `CHK(starts[p], s + 8'h01)
    rd_chk(pdl_pkg::TEST_CTRL_IDX[p], {1'b0, r[10:9], 4'h0,
      r[8]});
    rd_chk(pdl_pkg::FAULT_DIST_IDX[p], r[7:0]);
    prev[p] = r;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset state: port 1 strapped autoneg on and 10M, port 2 the reverse
    rd_chk(pdl_pkg::LINK_CTRL_IDX[0], 8'ha0);
    rd_chk(pdl_pkg::LINK_CTRL_IDX[1], 8'h60);
    for (int p = 0; p < 2; p++) begin
      rd_chk(pdl_pkg::TEST_CTRL_IDX[p], 8'h00);
      rd_chk(pdl_pkg::FAULT_DIST_IDX[p], 8'h00);
    end
    `CHK({phy_ctrl[1].an_enable, phy_ctrl[0].an_enable}, 2'h1)
    `CHK({phy_ctrl[1].speed_100, phy_ctrl[0].speed_100}, 2'h2)
    `CHK(phy_ctrl[1].duplex_forced, 1'b1)
    // Link control: each entry is write data and autoneg failure
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        w = (i < 2) ? 8'hff : ((i == 2) ? 8'h40 : 8'h20);
        an_fail[p] <= (i == 0 || i == 3);
        bus(1'b1, pdl_pkg::LINK_CTRL_IDX[p], w);
        settle();
        rd_chk(pdl_pkg::LINK_CTRL_IDX[p], w & 8'he0);
        `CHK(phy_ctrl[p].an_enable, w[7])
        `CHK(phy_ctrl[p].speed_100, w[6])
        `CHK(phy_ctrl[p].duplex_full, w[5])
        `CHK(phy_ctrl[p].duplex_forced, !w[7] | an_fail[p])
      end
    end
    // Forced link pass and remote loopback
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, pdl_pkg::TEST_CTRL_IDX[p], 8'h0a);
      settle();
      rd_chk(pdl_pkg::TEST_CTRL_IDX[p], 8'h0a);
      `CHK(phy_ctrl[p].link_pass, 1'b1)
      `CHK(phy_ctrl[p].remote_loopback, 1'b1)
      bus(1'b1, pdl_pkg::TEST_CTRL_IDX[p], 8'h00);
      link_up[p] <= 1'b1;
      settle();
      `CHK(phy_ctrl[p].link_pass, 1'b1)
      `CHK(phy_ctrl[p].remote_loopback, 1'b0)
      link_up[p] <= 1'b0;
      settle();
      `CHK(phy_ctrl[p].link_pass, 1'b0)
    end
    // Cable tests, every outcome code with boundary counts
    for (int p = 0; p < 2; p++) begin
      cable(p, {2'h0, 9'h1ff});
      cable(p, {2'h1, 9'h100});
      cable(p, {2'h2, 9'h0ab});
      cable(p, {2'h3, 9'h001});
      // Read-only fields refuse writes
      bus(1'b1, pdl_pkg::FAULT_DIST_IDX[p], 8'hfe);
      rd_chk(pdl_pkg::FAULT_DIST_IDX[p], 8'h01);
      bus(1'b1, pdl_pkg::TEST_CTRL_IDX[p], 8'h05);
      rd_chk(pdl_pkg::TEST_CTRL_IDX[p], 8'h60);
    end
    // Unmapped index: write ignored, read zero
    bus(1'b1, 8'h1d, 8'hff);
    rd_chk(8'h1d, 8'h00);
    rd_chk(8'h00, 8'h00);
    complete_run();
  end
endmodule // tb_top
